/* include/fsc_pkg.sv */
// Purpose: shared constants for the fiber status and control registers
// Assumes: 100 MHz clock, 16-bit register data
// Notes: offsets are register indices on the plain register port
package fsc_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int         ADDR_W      = 5;
  localparam int         DATA_W      = 16;
  localparam logic [4:0] EXT_CAP_OFS = 5'h0f;
  localparam logic [4:0] CTRL1_OFS   = 5'h10;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int EXT_X_FD_BIT   = 15;
  localparam int EXT_X_HD_BIT   = 14;
  localparam int BLK_EXT_BIT    = 13;
  localparam int RSV12_BIT      = 12;
  localparam int CRS_TX_BIT     = 11;
  localparam int FORCE_LINK_BIT = 10;
  localparam int LOOP_TYPE_BIT  = 8;
  localparam int RF_FAST_BIT    = 5;
  localparam int RF_STD_BIT     = 4;
  localparam int IRQ_POL_BIT    = 2;
  // ----------------------------------------
  // reset values and masks
  // ----------------------------------------
  localparam logic [15:0] CTRL1_RST   = 16'h400c;
  localparam logic [15:0] CTRL1_WMASK = 16'hfffc;
  localparam logic [15:0] CTRL1_SWUPD = 16'h10c8;
  localparam logic [1:0]  MODE_FX     = 2'h0;
  // ----------------------------------------
  // receive symbols
  // ----------------------------------------
  localparam logic [7:0] RXD_IDLE     = 8'h00;
  localparam logic [7:0] RXD_CEXT     = 8'h0f;
  localparam logic [7:0] RXD_CEXT_ERR = 8'h1f;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_KHZ     = 100000;
  localparam int RF_FAST_MS  = 2;
  localparam int RF_STD_MS   = 20;
  localparam int RF_FAST_CYC = RF_FAST_MS * CLK_KHZ;
  localparam int RF_STD_CYC  = RF_STD_MS * CLK_KHZ;
  localparam int RF_CNT_W    = 21;
  localparam int LOOP_W      = 10;
  // ----------------------------------------
  // remote fault timer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    RF_IDLE = 2'b00,
    RF_WAIT = 2'b01,
    RF_SIG  = 2'b10
  } fsc_rf_state_t;
endpackage

/* logic/fsc_rf_timer.sv */
// Purpose: remote fault indication delay timer
// Assumes: fault is synchronous, counts at least 2
// Notes: fast enable wins when both enables are set
`timescale 1ns/1ps
`default_nettype none
module fsc_rf_timer
  import fsc_pkg::*;
#(
  parameter int unsigned FAST_CYC = RF_FAST_CYC,
  parameter int unsigned STD_CYC  = RF_STD_CYC,
  parameter int          CNT_W    = RF_CNT_W
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic fault,
  input  wire logic fast_en,
  input  wire logic std_en,
  output logic      rf_ind
);
  localparam logic [CNT_W-1:0] FAST_LIM = CNT_W'(FAST_CYC - 1);
  // fast stays inside its span, standard waits the full span
  localparam logic [CNT_W-1:0] STD_LIM  = CNT_W'(STD_CYC);

  fsc_rf_state_t    st_q;
  fsc_rf_state_t    st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] lim;
  logic             armed;

  // ----------------------------------------
  // limit select
  // ----------------------------------------
  assign armed = fast_en | std_en;
  assign lim   = fast_en ? FAST_LIM : STD_LIM;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      RF_IDLE: if (fault && armed) st_d = RF_WAIT;
      RF_WAIT: begin
        if (!fault || !armed) st_d = RF_IDLE;
        else if (cnt_q == lim) st_d = RF_SIG;
      end
      RF_SIG: if (!fault || !armed) st_d = RF_IDLE;
      default: st_d = RF_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= RF_IDLE;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= (st_q == RF_WAIT) ? cnt_q + 1'b1 : CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rf_ind <= 1'b0;
    end else if (ce) begin
      rf_ind <= (st_d == RF_SIG);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_rf_fast;
    @(posedge clk) disable iff (!rst_n)
    $rose(rf_ind) && $past(fast_en) |-> $past(cnt_q) == FAST_LIM;
  endproperty
  a_rf_fast: assert property (p_rf_fast)
    else $error("fast remote fault not at its count");

  property p_rf_std;
    @(posedge clk) disable iff (!rst_n)
    $rose(rf_ind) && !$past(fast_en) |-> $past(cnt_q) == STD_LIM;
  endproperty
  a_rf_std: assert property (p_rf_std)
    else $error("standard remote fault not at its count");
endmodule // fsc_rf_timer
`default_nettype wire

/* logic/fsc_regs.sv */
// Purpose: fiber extended capability and control register logic
// Assumes: all inputs synchronous to CLK
// Notes: plain register port, read data one cycle after strobe
//
// Contract
// - Extended capability 1000BASE-X duplex bits read 0 in mode 00, else 1.
// - Extended capability 1000BASE-T bits and low reserved field read 0.
// - Blocking on in full duplex turns carrier extension symbols to idle.
// - Transmit carrier sense bit asserts CRS while sending, not in full duplex.
// - Force link good bypasses link monitoring and holds link up.
// - Loopback type 0 loops through the PCS path, 1 loops raw 10-bit groups.
// - Fast remote fault enable signals the fault within 2 ms.
// - Standard remote fault enable signals the fault after 20 ms.
// - Read-only mode field mirrors the programmed operating mode.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fsc_regs
  import fsc_pkg::*;
#(
  parameter int unsigned FAST_CYC = RF_FAST_CYC,
  parameter int unsigned STD_CYC  = RF_STD_CYC
) (
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              CE,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WR_DATA,
  input  wire logic              WR_EN,
  input  wire logic              RD_EN,
  output logic      [DATA_W-1:0] RD_DATA,
  input  wire logic              SOFT_RST,
  input  wire logic [1:0]        MODE_SEL,
  input  wire logic              FULL_DUPLEX,
  input  wire logic [7:0]        RXD_IN,
  input  wire logic              RX_DV_IN,
  input  wire logic              RX_ER_IN,
  output logic      [7:0]        RXD_OUT,
  output logic                   RX_DV_OUT,
  output logic                   RX_ER_OUT,
  input  wire logic              TX_EN,
  input  wire logic              RX_CRS_IN,
  output logic                   CRS_OUT,
  input  wire logic              LINK_MON_IN,
  output logic                   LINK_UP,
  input  wire logic              LOOP_EN,
  input  wire logic [LOOP_W-1:0] PCS_LOOP_CODE,
  input  wire logic [LOOP_W-1:0] RAW_TX_CODE,
  output logic      [LOOP_W-1:0] LOOP_CODE,
  output logic                   LOOP_RAW,
  input  wire logic              FAULT_IN,
  output logic                   RF_IND_OUT,
  input  wire logic              IRQ_EVENT,
  output logic                   IRQ_PIN_N
);
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [15:0] ext_val;
  logic [15:0] ctrl_val;
  logic [15:0] rdata_d;
  logic        cext_sym;
  logic        blk_now;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    if (WR_EN && ADDR == CTRL1_OFS) begin
      ctrl_d = WR_DATA & CTRL1_WMASK;
    end
    if (SOFT_RST) begin
      ctrl_d = (ctrl_d & ~CTRL1_SWUPD) | (CTRL1_RST & CTRL1_SWUPD);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= CTRL1_RST;
    end else if (CE) begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    ext_val = '0;
    ext_val[EXT_X_FD_BIT] = (MODE_SEL != MODE_FX);
    ext_val[EXT_X_HD_BIT] = (MODE_SEL != MODE_FX);
  end

  assign ctrl_val = {ctrl_q[15:2], MODE_SEL};

  always_comb begin
    rdata_d = '0;
    if (RD_EN) begin
      unique case (ADDR)
        EXT_CAP_OFS: rdata_d = ext_val;
        CTRL1_OFS:   rdata_d = ctrl_val;
        default:     rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_DATA <= '0;
    end else if (CE) begin
      RD_DATA <= rdata_d;
    end
  end

  // ----------------------------------------
  // receive carrier extension filter
  // ----------------------------------------
  assign cext_sym = !RX_DV_IN && RX_ER_IN &&
                    (RXD_IN == RXD_CEXT || RXD_IN == RXD_CEXT_ERR);
  assign blk_now  = ctrl_q[BLK_EXT_BIT] && FULL_DUPLEX && cext_sym;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RXD_OUT   <= RXD_IDLE;
      RX_DV_OUT <= 1'b0;
      RX_ER_OUT <= 1'b0;
    end else if (CE) begin
      RXD_OUT   <= blk_now ? RXD_IDLE : RXD_IN;
      RX_DV_OUT <= RX_DV_IN;
      RX_ER_OUT <= blk_now ? 1'b0 : RX_ER_IN;
    end
  end

  // ----------------------------------------
  // carrier sense
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CRS_OUT <= 1'b0;
    end else if (CE) begin
      CRS_OUT <= RX_CRS_IN ||
                 (TX_EN && ctrl_q[CRS_TX_BIT] && !FULL_DUPLEX);
    end
  end

  // ----------------------------------------
  // link indication
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LINK_UP <= 1'b0;
    end else if (CE) begin
      LINK_UP <= ctrl_q[FORCE_LINK_BIT] || LINK_MON_IN;
    end
  end

  // ----------------------------------------
  // loopback select
  // ----------------------------------------
  assign LOOP_RAW = ctrl_q[LOOP_TYPE_BIT];

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LOOP_CODE <= '0;
    end else if (CE) begin
      if (!LOOP_EN) begin
        LOOP_CODE <= '0;
      end else begin
        LOOP_CODE <= LOOP_RAW ? RAW_TX_CODE : PCS_LOOP_CODE;
      end
    end
  end

  // ----------------------------------------
  // remote fault timer
  // ----------------------------------------
  fsc_rf_timer #(
    .FAST_CYC (FAST_CYC),
    .STD_CYC  (STD_CYC),
    .CNT_W    (RF_CNT_W)
  ) u_rf (
    .clk     (CLK),
    .rst_n   (RST_N),
    .ce      (CE),
    .fault   (FAULT_IN),
    .fast_en (ctrl_q[RF_FAST_BIT]),
    .std_en  (ctrl_q[RF_STD_BIT]),
    .rf_ind  (RF_IND_OUT)
  );

  // ----------------------------------------
  // interrupt pin polarity
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ_PIN_N <= 1'b1;
    end else if (CE) begin
      IRQ_PIN_N <= IRQ_EVENT ^ ctrl_q[IRQ_POL_BIT];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_rd_ext;
    CE && RD_EN && ADDR == EXT_CAP_OFS;
  endsequence

  sequence s_rd_ctrl;
    CE && RD_EN && ADDR == CTRL1_OFS;
  endsequence

  sequence s_ctrl_wr;
    CE && !SOFT_RST && WR_EN && ADDR == CTRL1_OFS;
  endsequence

  property p_ext_dup;
    s_rd_ext |=>
      RD_DATA[15:14] == {2{$past(MODE_SEL) != MODE_FX}};
  endproperty
  a_ext_dup: assert property (p_ext_dup)
    else $error("duplex capability bits wrong for mode");

  property p_ext_zero;
    s_rd_ext |=> RD_DATA[13:0] == 14'h0000;
  endproperty
  a_ext_zero: assert property (p_ext_zero)
    else $error("extended capability low bits not zero");

  property p_blk_ext;
    CE && blk_now |=> RXD_OUT == RXD_IDLE && !RX_ER_OUT;
  endproperty
  a_blk_ext: assert property (p_blk_ext)
    else $error("carrier extension passed while blocked");

  property p_crs_tx;
    CE && !RX_CRS_IN && (!ctrl_q[CRS_TX_BIT] || FULL_DUPLEX)
      |=> !CRS_OUT;
  endproperty
  a_crs_tx: assert property (p_crs_tx)
    else $error("carrier sense raised by transmit");

  property p_crs_on;
    CE && TX_EN && ctrl_q[CRS_TX_BIT] && !FULL_DUPLEX |=> CRS_OUT;
  endproperty
  a_crs_on: assert property (p_crs_on)
    else $error("carrier sense missing on transmit");

  property p_force_link;
    CE && ctrl_q[FORCE_LINK_BIT] |=> LINK_UP;
  endproperty
  a_force_link: assert property (p_force_link)
    else $error("forced link not up");

  property p_loop_type;
    s_ctrl_wr |=> LOOP_RAW == $past(WR_DATA[LOOP_TYPE_BIT]) ##1
      (!$past(CE) || !$past(LOOP_EN) || !$past(LOOP_RAW) ||
       LOOP_CODE == $past(RAW_TX_CODE));
  endproperty
  a_loop_type: assert property (p_loop_type)
    else $error("loopback type not taken from write");

  property p_irq_pol;
    CE |=> IRQ_PIN_N ==
      ($past(IRQ_EVENT) ^ $past(ctrl_q[IRQ_POL_BIT]));
  endproperty
  a_irq_pol: assert property (p_irq_pol)
    else $error("interrupt pin polarity wrong");

  property p_mode_mirror;
    s_rd_ctrl |=> RD_DATA[1:0] == $past(MODE_SEL);
  endproperty
  a_mode_mirror: assert property (p_mode_mirror)
    else $error("mode field does not mirror mode");

  property p_soft_rst;
    CE && SOFT_RST && !WR_EN |=>
      !ctrl_q[RSV12_BIT] &&
      ctrl_q[BLK_EXT_BIT] == $past(ctrl_q[BLK_EXT_BIT]) &&
      ctrl_q[IRQ_POL_BIT] == $past(ctrl_q[IRQ_POL_BIT]);
  endproperty
  a_soft_rst: assert property (p_soft_rst)
    else $error("soft reset changed config or kept bit 12");

  property p_soft_keep;
    CE && SOFT_RST && !WR_EN |=>
      ctrl_q[11:8] == $past(ctrl_q[11:8]) &&
      ctrl_q[5:4] == $past(ctrl_q[5:4]) && ctrl_q[3];
  endproperty
  a_soft_keep: assert property (p_soft_keep)
    else $error("soft reset lost a control bit");

  property p_rx_pass;
    CE && !(ctrl_q[BLK_EXT_BIT] && FULL_DUPLEX) |=>
      RXD_OUT == $past(RXD_IN) && RX_ER_OUT == $past(RX_ER_IN) &&
      RX_DV_OUT == $past(RX_DV_IN);
  endproperty
  a_rx_pass: assert property (p_rx_pass)
    else $error("receive symbol altered while not blocking");

  property p_crs_rx;
    CE && RX_CRS_IN |=> CRS_OUT;
  endproperty
  a_crs_rx: assert property (p_crs_rx)
    else $error("receive carrier not shown on carrier sense");

  property p_link_norm;
    CE && !ctrl_q[FORCE_LINK_BIT] |=> LINK_UP == $past(LINK_MON_IN);
  endproperty
  a_link_norm: assert property (p_link_norm)
    else $error("link does not follow the monitor");

  property p_loop_pcs;
    CE && LOOP_EN && !LOOP_RAW |=> LOOP_CODE == $past(PCS_LOOP_CODE);
  endproperty
  a_loop_pcs: assert property (p_loop_pcs)
    else $error("pcs loopback code wrong");

  property p_loop_raw;
    CE && LOOP_EN && LOOP_RAW |=> LOOP_CODE == $past(RAW_TX_CODE);
  endproperty
  a_loop_raw: assert property (p_loop_raw)
    else $error("raw loopback code wrong");

  property p_loop_off;
    CE && !LOOP_EN |=> LOOP_CODE == '0;
  endproperty
  a_loop_off: assert property (p_loop_off)
    else $error("loopback code not idle while off");

  property p_rf_clear;
    CE && !FAULT_IN |=> !RF_IND_OUT;
  endproperty
  a_rf_clear: assert property (p_rf_clear)
    else $error("remote fault shown without a fault");

  property p_ctrl_wr;
    s_ctrl_wr |=> ctrl_q[15:2] == $past(WR_DATA[15:2]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr)
    else $error("control write not stored");

  property p_rd_idle;
    CE && !RD_EN |=> RD_DATA == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not cleared after read");
endmodule // fsc_regs
`default_nettype wire

/* bench/fsc_lp_model.sv */
// Purpose: fiber link partner model, source of receive symbols
// Assumes: symbols change right after a rising edge
// Notes: each symbol lasts one cycle, idle code before and after
`timescale 1ns/1ps
`default_nettype none
module fsc_lp_model (
  input  wire logic       clk,
  output logic      [7:0] rxd,
  output logic            rx_dv,
  output logic            rx_er
);
  initial begin
    rxd   = 8'h00;
    rx_dv = 1'b0;
    rx_er = 1'b0;
  end
  // one symbol, then back to idle
  task automatic send(input logic [7:0] d, input logic dv, input logic er);
    @(posedge clk);
    rxd   <= d;
    rx_dv <= dv;
    rx_er <= er;
    @(posedge clk);
    rxd   <= 8'h00;
    rx_dv <= 1'b0;
    rx_er <= 1'b0;
  endtask
endmodule // fsc_lp_model
`default_nettype wire

/* bench/tb.sv */
// Purpose: self-checking bench for the fiber status and control registers
// Assumes: short remote fault counts of 4 and 10 cycles
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fsc_pkg::*;
  localparam logic [15:0] CFG = 16'h6d2c;
  logic              clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [ADDR_W-1:0] addr = 5'h00;
  logic [DATA_W-1:0] wdata = 16'h0000, rdata;
  logic [1:0]        mode = 2'h0;
  logic [9:0]        pcs_code = 10'h155, raw_code = 10'h2aa, loop_code;
  logic [7:0]        rxd_in, rxd_out;
  logic soft_rst = 1'b0, fdx = 1'b0, tx_en = 1'b0, rx_crs = 1'b0;
  logic link_mon = 1'b0, loop_en = 1'b0, fault = 1'b0, irq_ev = 1'b0;
  logic ce = 1'b1;
  logic dv_in, er_in, dv_out, er_out, crs, link_up, loop_raw, rf_ind, irq_n;
  logic [15:0] v;
  int   fails = 0, num_checks = 0, k;

  always #5 clk = ~clk;

  fsc_regs #(.FAST_CYC(4), .STD_CYC(10)) i_fsc_regs (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .ADDR(addr), .WR_DATA(wdata),
    .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rdata), .SOFT_RST(soft_rst),
    .MODE_SEL(mode), .FULL_DUPLEX(fdx), .RXD_IN(rxd_in), .RX_DV_IN(dv_in),
    .RX_ER_IN(er_in), .RXD_OUT(rxd_out), .RX_DV_OUT(dv_out),
    .RX_ER_OUT(er_out), .TX_EN(tx_en), .RX_CRS_IN(rx_crs), .CRS_OUT(crs),
    .LINK_MON_IN(link_mon), .LINK_UP(link_up), .LOOP_EN(loop_en),
    .PCS_LOOP_CODE(pcs_code), .RAW_TX_CODE(raw_code),
    .LOOP_CODE(loop_code), .LOOP_RAW(loop_raw), .FAULT_IN(fault),
    .RF_IND_OUT(rf_ind), .IRQ_EVENT(irq_ev), .IRQ_PIN_N(irq_n)
  );
  fsc_lp_model i_fsc_lp_model (
    .clk(clk), .rxd(rxd_in), .rx_dv(dv_in), .rx_er(er_in)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(EXT_CAP_OFS, v); chk(v, 16'h0000);
    rd(CTRL1_OFS, v); chk(v, 16'h400c);
    chk({15'h0000, irq_n}, 16'h0001);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      mode <= m[1:0];
      settle;
      rd(EXT_CAP_OFS, v); chk(v, (m == 0) ? 16'h0000 : 16'hc000);
      rd(CTRL1_OFS, v); chk(v, 16'h400c | 16'(m));
    end
  endtask
  task automatic t_regs;
    wr(CTRL1_OFS, CFG | 16'h0003);
    rd(CTRL1_OFS, v); chk(v, CFG | 16'h0003);
    wr(EXT_CAP_OFS, 16'h3fff);
    rd(EXT_CAP_OFS, v); chk(v, 16'hc000);
    wr(5'h11, 16'hffff);
    rd(5'h11, v); chk(v, 16'h0000);
  endtask
  task automatic t_rx;
    @(posedge clk);
    fdx <= 1'b1;
    i_fsc_lp_model.send(8'h0f, 1'b0, 1'b1);
    #1 chk({6'h00, rxd_out, dv_out, er_out}, 16'h0000);
    i_fsc_lp_model.send(8'h1f, 1'b0, 1'b1);
    #1 chk({6'h00, rxd_out, dv_out, er_out}, 16'h0000);
    i_fsc_lp_model.send(8'h55, 1'b1, 1'b0);
    #1 chk({6'h00, rxd_out, dv_out, er_out}, 16'h0156);
    @(posedge clk);
    fdx <= 1'b0;
    i_fsc_lp_model.send(8'h0f, 1'b0, 1'b1);
    #1 chk({6'h00, rxd_out, dv_out, er_out}, 16'h003d);
  endtask
  task automatic t_ctrl_bits;
    @(posedge clk);
    tx_en   <= 1'b1;
    loop_en <= 1'b1;
    settle;
    chk({15'h0000, crs}, 16'h0001);
    chk({15'h0000, link_up}, 16'h0001);
    chk({5'h00, loop_raw, loop_code}, 16'h06aa);
    wr(CTRL1_OFS, 16'h400c);
    settle;
    chk({15'h0000, crs}, 16'h0000);
    chk({15'h0000, link_up}, 16'h0000);
    chk({5'h00, loop_raw, loop_code}, 16'h0155);
    @(posedge clk);
    link_mon <= 1'b1;
    rx_crs   <= 1'b1;
    tx_en    <= 1'b0;
    settle;
    chk({15'h0000, link_up}, 16'h0001);
    chk({15'h0000, crs}, 16'h0001);
  endtask
  task automatic rf_wait;
    @(posedge clk);
    fault <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (rf_ind !== 1'b1 && k < 40);
  endtask
  task automatic t_rf;
    wr(CTRL1_OFS, 16'h402c);
    rf_wait; chk(16'(k), 16'h0004);
    @(posedge clk);
    fault <= 1'b0;
    settle;
    wr(CTRL1_OFS, 16'h401c);
    rf_wait; chk(16'(k), 16'h000b);
    @(posedge clk);
    fault <= 1'b0;
    settle;
    chk({15'h0000, rf_ind}, 16'h0000);
  endtask
  task automatic t_irq;
    @(posedge clk);
    irq_ev <= 1'b1;
    settle;
    chk({15'h0000, irq_n}, 16'h0000);
    wr(CTRL1_OFS, 16'h4008);
    settle;
    chk({15'h0000, irq_n}, 16'h0001);
    @(posedge clk);
    irq_ev <= 1'b0;
    settle;
    chk({15'h0000, irq_n}, 16'h0000);
  endtask
  task automatic t_resets;
    wr(CTRL1_OFS, CFG);
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    rd(CTRL1_OFS, v); chk(v, CFG | 16'h0003);
    @(posedge clk);
    rst_n <= 1'b0;
    settle;
    @(posedge clk);
    rst_n <= 1'b1;
    rd(CTRL1_OFS, v); chk(v, 16'h400f);
  endtask
  task automatic t_ce;
    @(posedge clk);
    ce <= 1'b0;
    wr(CTRL1_OFS, 16'h6d2c);
    rd(CTRL1_OFS, v);
    @(posedge clk);
    ce <= 1'b1;
    chk(v, 16'h0000);
    rd(CTRL1_OFS, v); chk(v, 16'h400f);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_modes;
    t_regs;
    t_rx;
    t_ctrl_bits;
    t_rf;
    t_irq;
    t_resets;
    t_ce;
    report_and_stop;
  end
  initial begin
    #50000;
    fails++;
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
